// ### hw/scsu_pair_buf.sv
// Small flop-based valid/ready buffer, two entries by default
`timescale 1ns/10ps
module scsu_pair_buf #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic   clock_i,
    input  wire logic   rst_n_i,
    // Data path
    scsu_buf_if.store   bq
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    wire           push;
    wire           pop;
    wire [AW-1:0]  wp_nx;
    wire [AW-1:0]  rp_nx;

    assign bq.in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign bq.out_valid = (cnt_q != '0);
    assign bq.out_data  = mem_q[rp_q];
    assign push  = bq.in_valid & bq.in_ready;
    assign pop   = bq.out_valid & bq.out_ready;
    assign wp_nx = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    assign rp_nx = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wp_q] <= bq.in_data;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_nx;
            end
            if (pop) begin
                rp_q <= rp_nx;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ### hw/scsu_spi_ctrl.sv
// SPI port control/status unit: registers, rate divider, master shifter
//
// Contract
// [RULE1] Bits go out and in MSB first when bit-order is 0, LSB first when 1.
// [RULE2] Master serial clock is system clock divided by 2, 4, 8 or 16.
// [RULE3] Done flag sets at frame end; cleared by interrupt vectoring or writing 0.
// [RULE4] Writing data while busy sets the write-collision flag.
// [RULE5] Collision flag clears on writing 0 or data write while not busy.
// [RULE6] Master with select pin used: select input low sets mode fault.
// [RULE7] Mode fault clears port enable and master select.
// [RULE8] Overrun sets at frame end if receive-full already set; clear by 0 or read.
// [RULE9] Receive-full sets at frame end; cleared by writing 0 or data read.
// [RULE10] Busy flag is high exactly while a transfer is in progress; here also while a byte is queued and two cycles after.
// [RULE11] One data register: writes transmit, reads return last received byte.
// [RULE12] Phase 0 samples on first clock edge of a bit, phase 1 on second.
// [RULE13] Enabled idle master starts an 8-bit frame on a data write.
// [RULE14] The peer keeps select high while this device is master.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "scsu_defs.svh"
module scsu_spi_ctrl
    import scsu_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // Register port
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic [7:0]      rdata_o,
    // Interrupt vectoring
    input  wire logic       int_ack_i,
    output logic            done_flag_o,
    // Serial pins
    output logic            sck_o,
    output logic            sck_oe_o,
    output logic            mosi_o,
    output logic            mosi_oe_o,
    input  wire logic       miso_i,
    input  wire logic       ss_n_i
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0]  ctrl_q;
    logic [7:0]  ctrl_d;
    logic        done_q;
    logic        wcol_q;
    logic        modf_q;
    logic        ovr_q;
    logic        rxf_q;
    logic [7:0]  rx_data_q;
    scsu_state_t state_q;
    logic [2:0]  div_q;
    logic [3:0]  edge_q;
    logic [7:0]  sh_q;
    logic [7:0]  sh_d;
    logic [7:0]  rx_sh_q;
    logic        sck_q;
    logic        oe_q;
    logic        mosi_q;
    logic [7:0]  rdata_q;
    logic        ss_m_q;
    logic        ss_s_q;
    logic        miso_m_q;
    logic        miso_s_q;
    logic [7:0]  cyc_q;
    logic        samp_p1_q;
    logic        samp_p2_q;
    logic        end_p1_q;
    logic        end_p2_q;

    scsu_buf_if #(.W(8)) bq ();

    scsu_pair_buf #(
        .W     (8),
        .DEPTH (2)
    ) u_txbuf (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .bq      (bq)
    );

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire       wr_ctrl  = wr_i & (addr_i == `SCSU_CTRL_OFS);
    wire       wr_stat  = wr_i & (addr_i == `SCSU_STAT_OFS);
    wire       wr_data  = wr_i & (addr_i == `SCSU_DATA_OFS);
    wire       rd_data  = rd_i & (addr_i == `SCSU_DATA_OFS);
    wire       en       = ctrl_q[`SCSU_EN_BIT];
    wire       master_select     = ctrl_q[`SCSU_MS_BIT];
    wire       cpol     = ctrl_q[`SCSU_POL_BIT];
    wire       clock_phase     = ctrl_q[`SCSU_PHA_BIT];
    wire       ssd      = ctrl_q[`SCSU_SSD_BIT];
    wire       low_bit_first     = ctrl_q[`SCSU_LSB_BIT];
    wire [1:0] rate     = ctrl_q[`SCSU_RATE_HI:`SCSU_RATE_LO];
    wire       shifting = (state_q == SCSU_SHIFT);
    // Queued byte counts as busy so a second write is flagged and dropped, not queued
    // Busy also spans the synchroniser tail of the last received bit
    wire       busy     = shifting | bq.out_valid | end_p1_q | end_p2_q; // [RULE10]
    wire       modf_set = en & master_select & ~ssd & ~ss_s_q; // [RULE6] [RULE14]
    // Half serial period minus one: 0, 1, 3, 7 cycles
    wire [2:0] half_m1  = (3'h1 << rate) - 3'h1; // [RULE2]
    wire       tick     = shifting & (div_q == half_m1);
    wire       samp_e   = tick & (edge_q[0] == clock_phase); // [RULE12]
    // Phase 1 presents bit 0 at the first edge, so no shift there
    wire       shift_e  = tick & (edge_q[0] != clock_phase) & ~(clock_phase & (edge_q == 4'h0));
    wire       xfer_end = tick & (edge_q == `SCSU_LAST_EDGE);
    wire [7:0] rx_next  = low_bit_first ? {miso_s_q, rx_sh_q[7:1]} : {rx_sh_q[6:0], miso_s_q}; // [RULE1]
    wire       start    = bq.out_valid & bq.out_ready;
    wire [7:0] stat_rd  = {done_q, wcol_q, modf_q, ovr_q, rxf_q, 2'b00, busy};

    // Writes while disabled, in slave mode or busy are dropped
    assign bq.in_data   = wdata_i;
    assign bq.in_valid  = wr_data & ~busy & en & master_select; // [RULE13]
    assign bq.out_ready = ~shifting & en & master_select & ~modf_set; // [RULE13]

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_d = wr_ctrl ? wdata_i : ctrl_q;
        if (modf_set) begin
            ctrl_d[`SCSU_EN_BIT] = 1'b0; // [RULE7]
            ctrl_d[`SCSU_MS_BIT] = 1'b0; // [RULE7]
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `SCSU_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ----------------------------------------------------------------
    // Status flags, set wins over clear
    // ----------------------------------------------------------------
    wire done_clr = int_ack_i | (wr_stat & ~wdata_i[`SCSU_DONE_BIT]);
    wire wcol_set = wr_data & busy;
    wire wcol_clr = (wr_data & ~busy) | (wr_stat & ~wdata_i[`SCSU_WCOL_BIT]);
    wire modf_clr = wr_stat & ~wdata_i[`SCSU_MODF_BIT];
    wire ovr_clr  = rd_data | (wr_stat & ~wdata_i[`SCSU_OVR_BIT]);
    wire rxf_clr  = rd_data | (wr_stat & ~wdata_i[`SCSU_RXF_BIT]);

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            done_q <= 1'b0;
            wcol_q <= 1'b0;
            modf_q <= 1'b0;
            ovr_q  <= 1'b0;
            rxf_q  <= 1'b0;
        end else begin
            done_q <= end_p2_q | (done_q & ~done_clr); // [RULE3]
            wcol_q <= wcol_set | (wcol_q & ~wcol_clr); // [RULE4] [RULE5]
            modf_q <= modf_set | (modf_q & ~modf_clr); // [RULE6]
            ovr_q  <= (end_p2_q & rxf_q) | (ovr_q & ~ovr_clr); // [RULE8]
            rxf_q  <= end_p2_q | (rxf_q & ~rxf_clr); // [RULE9]
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ss_m_q   <= 1'b1;
            ss_s_q   <= 1'b1;
            miso_m_q <= 1'b0;
            miso_s_q <= 1'b0;
        end else begin
            ss_m_q   <= ss_n_i;
            ss_s_q   <= ss_m_q;
            miso_m_q <= miso_i;
            miso_s_q <= miso_m_q;
        end
    end

    // ----------------------------------------------------------------
    // Shifter
    // ----------------------------------------------------------------
    always_comb begin
        sh_d = sh_q;
        if (start) begin
            sh_d = bq.out_data;
        end else if (shift_e) begin
            sh_d = low_bit_first ? {1'b0, sh_q[7:1]} : {sh_q[6:0], 1'b0}; // [RULE1]
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_q <= SCSU_IDLE;
            div_q   <= 3'h0;
            edge_q  <= 4'h0;
            sh_q    <= 8'h00;
            mosi_q  <= 1'b0;
            rx_sh_q <= 8'h00;
            samp_p1_q <= 1'b0;
            samp_p2_q <= 1'b0;
            end_p1_q  <= 1'b0;
            end_p2_q  <= 1'b0;
        end else begin
            sh_q   <= sh_d;
            mosi_q <= low_bit_first ? sh_d[0] : sh_d[7]; // [RULE1]
            // Mode fault aborts a frame in flight
            if (modf_set || !shifting || tick) begin
                div_q <= 3'h0;
            end else begin
                div_q <= div_q + 3'h1; // [RULE2]
            end
            // Miso lags two cycles in its synchroniser, so capture and frame end wait too
            samp_p1_q <= samp_e;
            samp_p2_q <= samp_p1_q;
            end_p1_q  <= xfer_end;
            end_p2_q  <= end_p1_q;
            if (samp_p2_q) begin
                rx_sh_q <= rx_next; // [RULE12]
            end
            case (state_q)
                SCSU_IDLE: begin
                    edge_q <= 4'h0;
                    if (start) begin
                        state_q <= SCSU_SHIFT; // [RULE13]
                    end
                end
                SCSU_SHIFT: begin
                    if (modf_set || xfer_end) begin
                        state_q <= SCSU_IDLE;
                    end
                    if (tick) begin
                        edge_q <= edge_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= SCSU_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rx_data_q <= `SCSU_DATA_RST;
        end else if (end_p2_q) begin
            // Phase 0 takes its last sample an edge before the frame ends
            rx_data_q <= samp_p2_q ? rx_next : rx_sh_q; // [RULE11]
        end
    end

    // ----------------------------------------------------------------
    // Pins and read port
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sck_q   <= 1'b0;
            oe_q    <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            oe_q <= ctrl_d[`SCSU_EN_BIT] & ctrl_d[`SCSU_MS_BIT];
            if (!shifting || modf_set) begin
                sck_q <= ctrl_d[`SCSU_POL_BIT];
            end else if (tick) begin
                sck_q <= ~sck_q; // [RULE2]
            end
            rdata_q <= 8'h00;
            if (rd_i) begin
                case (addr_i)
                    `SCSU_CTRL_OFS: rdata_q <= ctrl_q;
                    `SCSU_STAT_OFS: rdata_q <= stat_rd; // [RULE10]
                    `SCSU_DATA_OFS: rdata_q <= rx_data_q; // [RULE11]
                    default:        rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign rdata_o     = rdata_q;
    assign done_flag_o = done_q;
    assign sck_o       = sck_q;
    assign sck_oe_o    = oe_q;
    assign mosi_o      = mosi_q;
    assign mosi_oe_o   = oe_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Cycles since frame start, lets the frame length be checked
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || start) begin
            cyc_q <= 8'h00;
        end else if (shifting) begin
            cyc_q <= cyc_q + 8'h01;
        end
    end

    chk_first_bit_order: assert property ( // [RULE1]
        @(posedge clock_i) disable iff (!rst_n_i)
        start |=> mosi_q == (low_bit_first ? $past(bq.out_data[0]) : $past(bq.out_data[7])))
        else $error("first serial bit has wrong order");

    chk_frame_rate_len: assert property ( // [RULE2]
        @(posedge clock_i) disable iff (!rst_n_i)
        xfer_end |-> cyc_q == ((8'h10 << rate) - 8'h01))
        else $error("frame length does not match rate divider");

    chk_done_set_ack: assert property ( // [RULE3]
        @(posedge clock_i) disable iff (!rst_n_i)
        end_p2_q |=> done_q ##1 (done_q || $past(done_clr)))
        else $error("done flag not set or lost");

    chk_done_vector_clr: assert property ( // [RULE3]
        @(posedge clock_i) disable iff (!rst_n_i)
        (int_ack_i && !end_p2_q) |=> !done_q)
        else $error("done flag not cleared on vectoring");

    chk_wcol_on_busy: assert property ( // [RULE4]
        @(posedge clock_i) disable iff (!rst_n_i)
        (wr_data && busy) |=> wcol_q && stat_rd[`SCSU_WCOL_BIT])
        else $error("collision flag not set");

    chk_wcol_rewrite_clr: assert property ( // [RULE5]
        @(posedge clock_i) disable iff (!rst_n_i)
        (wr_data && !busy) |=> !wcol_q)
        else $error("collision flag not cleared by idle write");

    chk_modf_disable: assert property ( // [RULE7]
        @(posedge clock_i) disable iff (!rst_n_i)
        modf_set |=> modf_q && !en && !master_select && !shifting ##1 !oe_q)
        else $error("mode fault did not disable port");

    chk_overrun_set: assert property ( // [RULE8]
        @(posedge clock_i) disable iff (!rst_n_i)
        (end_p2_q && rxf_q) |=> ovr_q && rxf_q)
        else $error("overrun not flagged");

    chk_read_clears_rx: assert property ( // [RULE9]
        @(posedge clock_i) disable iff (!rst_n_i)
        (rd_data && !end_p2_q) |=> !rxf_q && !ovr_q && rdata_o == $past(rx_data_q))
        else $error("data read did not clear receive flags");

    chk_busy_in_frame: assert property ( // [RULE10]
        @(posedge clock_i) disable iff (!rst_n_i)
        (rd_i && addr_i == `SCSU_STAT_OFS) |=> rdata_o[`SCSU_BSY_BIT] == $past(busy))
        else $error("busy bit does not follow transfer");

    chk_write_starts: assert property ( // [RULE13]
        @(posedge clock_i) disable iff (!rst_n_i)
        (bq.in_valid && bq.in_ready && !modf_set) |=> ##1 shifting || modf_q)
        else $error("data write did not start a frame");

endmodule

// ### inc/scsu_buf_if.sv
// Valid/ready carrier between the unit and its transmit buffer
`timescale 1ns/10ps
interface scsu_buf_if #(
    parameter int W = 8
);
    logic [W-1:0] in_data;
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] out_data;
    logic         out_valid;
    logic         out_ready;

    modport store (input in_data, input in_valid, output in_ready,
                   output out_data, output out_valid, input out_ready);
    modport user  (output in_data, output in_valid, input in_ready,
                   input out_data, input out_valid, output out_ready);
endinterface

// ### inc/scsu_defs.svh
// Register map, field positions, reset values and counts of the SPI control/status unit
`ifndef SCSU_DEFS_SVH
`define SCSU_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SCSU_CTRL_OFS   8'hbc
`define SCSU_STAT_OFS   8'hbd
`define SCSU_DATA_OFS   8'hbe

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define SCSU_EN_BIT     7
`define SCSU_MS_BIT     6
`define SCSU_POL_BIT    5
`define SCSU_PHA_BIT    4
`define SCSU_SSD_BIT    3
`define SCSU_LSB_BIT    2
`define SCSU_RATE_HI    1
`define SCSU_RATE_LO    0

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define SCSU_DONE_BIT   7
`define SCSU_WCOL_BIT   6
`define SCSU_MODF_BIT   5
`define SCSU_OVR_BIT    4
`define SCSU_RXF_BIT    3
`define SCSU_BSY_BIT    0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SCSU_CTRL_RST   8'h00
`define SCSU_DATA_RST   8'h00
`define SCSU_LAST_EDGE  4'hf

`endif

// ### inc/scsu_pkg.sv
// Types shared by the SPI control/status unit
package scsu_pkg;

    typedef enum logic [0:0] {
        SCSU_IDLE  = 1'b0,
        SCSU_SHIFT = 1'b1
    } scsu_state_t;

endpackage

// ### testbench/scsu_peer.sv
// Behavioural SPI slave peer facing the master shifter
`timescale 1ns/10ps
module scsu_peer (
    // Serial pins
    input  wire logic sck_i,
    input  wire logic mosi_i,
    output logic      miso_o,
    output logic      ss_n_o
);
    // ----------------------------------------------------------------
    // Frame state
    // ----------------------------------------------------------------
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic       lsb_q;
    logic       pha_q;
    int         edge_q;
    int         idx;

    initial begin
        ss_n_o = 1'b1;
        miso_o = 1'b0;
        tx_q   = 8'h00;
        rx_q   = 8'h00;
        lsb_q  = 1'b0;
        pha_q  = 1'b0;
        edge_q = 0;
    end

    // First bit is put out before the frame, as phase 0 samples on edge 0
    task automatic load(input logic [7:0] b, input logic lsb, input logic pha);
        tx_q   = b;
        lsb_q  = lsb;
        pha_q  = pha;
        edge_q = 0;
        rx_q   = 8'h00;
        miso_o = lsb ? b[0] : b[7];
    endtask

    task automatic drive_select(input logic v);
        ss_n_o = v;
    endtask

    // ----------------------------------------------------------------
    // Sample and shift on alternate serial clock edges
    // ----------------------------------------------------------------
    always @(sck_i) begin
        if (edge_q < 16) begin
            if (edge_q[0] == pha_q) begin
                rx_q = lsb_q ? {mosi_i, rx_q[7:1]} : {rx_q[6:0], mosi_i};
            end else begin
                idx = (edge_q + 1 - int'(pha_q)) / 2;
                if (idx < 8) begin
                    miso_o = lsb_q ? tx_q[idx] : tx_q[7-idx];
                end
            end
            edge_q = edge_q + 1;
            // Released after the last edge: show the inverse, not a held value
            if (edge_q == 16) begin
                miso_o = ~miso_o;
            end
        end
    end
endmodule

// ### testbench/test_scsu_spi_ctrl.sv
// Self-checking bench of the SPI control/status unit
`timescale 1ns/10ps
`include "scsu_defs.svh"
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module test_scsu_spi_ctrl;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic       clock_i;
    logic       rst_n_i;
    logic [7:0] addr_i;
    logic [7:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    logic [7:0] rdata_o;
    logic       int_ack_i;
    logic       done_flag_o;
    logic       sck_o;
    logic       sck_oe_o;
    logic       mosi_o;
    logic       mosi_oe_o;
    logic       miso_i;
    logic       ss_n_i;
    int         err_total;
    int         cmp_count;
    int         edge_n;
    int         gap;
    int         gap_min;
    int         gap_max;
    logic       sck_q;
    logic [7:0] v;

    scsu_spi_ctrl u_scsu_spi_ctrl (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .addr_i      (addr_i),
        .wdata_i     (wdata_i),
        .wr_i        (wr_i),
        .rd_i        (rd_i),
        .rdata_o     (rdata_o),
        .int_ack_i   (int_ack_i),
        .done_flag_o (done_flag_o),
        .sck_o       (sck_o),
        .sck_oe_o    (sck_oe_o),
        .mosi_o      (mosi_o),
        .mosi_oe_o   (mosi_oe_o),
        .miso_i      (miso_i),
        .ss_n_i      (ss_n_i)
    );

    scsu_peer u_peer (
        .sck_i  (sck_o),
        .mosi_i (mosi_o),
        .miso_o (miso_i),
        .ss_n_o (ss_n_i)
    );

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // Serial clock edge count and spacing in system cycles
    always @(posedge clock_i) begin
        if (sck_o !== sck_q) begin
            if (edge_n > 0 && gap < gap_min) gap_min = gap;
            if (edge_n > 0 && gap > gap_max) gap_max = gap;
            edge_n = edge_n + 1;
            gap    = 1;
        end else begin
            gap = gap + 1;
        end
        sck_q = sck_o;
    end

    // ----------------------------------------------------------------
    // Register port tasks
    // ----------------------------------------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        @(negedge clock_i);
        d = rdata_o;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] d;
        reg_rd(a, d);
        `CHK(nm, exp, d)
        @(negedge clock_i);
        `CHK("read data idle", 8'h00, rdata_o)
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        while (done_flag_o !== 1'b1 && n < 600) begin
            @(negedge clock_i);
            n++;
        end
        `CHK("done flag", 1'b1, done_flag_o)
    endtask

    task automatic frame(input logic [1:0] r, input logic lsb, input logic pha,
                         input logic [7:0] tx, input logic [7:0] px);
        logic [7:0] cfg;
        cfg = {2'b11, 1'b0, pha, 1'b0, lsb, r};
        u_peer.load(px, lsb, pha);
        reg_wr(`SCSU_CTRL_OFS, cfg);
        rd_chk(`SCSU_CTRL_OFS, cfg, "control");
        edge_n  = 0;
        gap_min = 999;
        gap_max = 0;
        reg_wr(`SCSU_DATA_OFS, tx);
        reg_rd(`SCSU_STAT_OFS, v);
        `CHK("busy in frame", 1'b1, v[`SCSU_BSY_BIT])
        wait_done();
        reg_rd(`SCSU_STAT_OFS, v);
        `CHK("busy after frame", 1'b0, v[`SCSU_BSY_BIT])
        `CHK("edge count", 16, edge_n)
        `CHK("half period min", 1 << r, gap_min)
        `CHK("half period max", 1 << r, gap_max)
        `CHK("peer received", tx, u_peer.rx_q)
    endtask

    task automatic drain(input logic [7:0] px, input logic by_ack);
        rd_chk(`SCSU_STAT_OFS, 8'h88, "status end");
        if (by_ack) begin
            @(posedge clock_i) int_ack_i <= 1'b1;
            @(posedge clock_i) int_ack_i <= 1'b0;
            @(negedge clock_i);
            `CHK("done after ack", 1'b0, done_flag_o)
            rd_chk(`SCSU_DATA_OFS, px, "data");
        end else begin
            reg_wr(`SCSU_STAT_OFS, 8'h00);
            rd_chk(`SCSU_STAT_OFS, 8'h00, "status cleared");
            rd_chk(`SCSU_DATA_OFS, px, "data");
        end
        rd_chk(`SCSU_STAT_OFS, 8'h00, "status idle");
    endtask

    task automatic finish_test;
        $display("errors %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        finish_test();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0; addr_i = 8'h00; wdata_i = 8'h00; wr_i = 1'b0; rd_i = 1'b0;
        int_ack_i = 1'b0; err_total = 0; cmp_count = 0; edge_n = 0; gap = 0;
        gap_min = 0; gap_max = 0; sck_q = 1'b0;
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        `CHK("sck enable", 1'b0, sck_oe_o)
        rd_chk(`SCSU_CTRL_OFS, `SCSU_CTRL_RST, "control reset");
        rd_chk(`SCSU_STAT_OFS, 8'h00, "status reset");
        rd_chk(`SCSU_DATA_OFS, `SCSU_DATA_RST, "data reset");
        reg_wr(8'hbf, 8'hff);
        rd_chk(8'hbf, 8'h00, "unmapped");
        reg_wr(`SCSU_STAT_OFS, 8'hff);
        rd_chk(`SCSU_STAT_OFS, 8'h00, "status set by write");
        // Every rate in both bit orders, then phase 1
        for (int i = 0; i < 8; i++) begin
            frame(i[2:1], i[0], 1'b0, 8'h1d + 8'(i * 3), 8'hd1 - 8'(i * 5));
            drain(8'hd1 - 8'(i * 5), i[0]);
        end
        frame(2'd3, 1'b0, 1'b1, 8'h4b, 8'h96);
        drain(8'h96, 1'b1);
        // Collision, overrun and their clearing paths
        frame(2'd0, 1'b0, 1'b0, 8'h5c, 8'ha3);
        reg_wr(`SCSU_STAT_OFS, 8'h7f);
        u_peer.load(8'h6e, 1'b0, 1'b0);
        reg_wr(`SCSU_DATA_OFS, 8'h71);
        reg_wr(`SCSU_DATA_OFS, 8'h99);
        wait_done();
        rd_chk(`SCSU_STAT_OFS, 8'hd8, "collision overrun");
        `CHK("peer kept first", 8'h71, u_peer.rx_q)
        u_peer.load(8'h27, 1'b0, 1'b0);
        reg_wr(`SCSU_STAT_OFS, 8'h7f);
        reg_wr(`SCSU_DATA_OFS, 8'h34);
        reg_rd(`SCSU_STAT_OFS, v);
        `CHK("collision off", 1'b0, v[`SCSU_WCOL_BIT])
        wait_done();
        reg_wr(`SCSU_STAT_OFS, 8'hef);
        rd_chk(`SCSU_STAT_OFS, 8'h88, "overrun write 0");
        u_peer.load(8'h58, 1'b0, 1'b0);
        reg_wr(`SCSU_STAT_OFS, 8'h7f);
        reg_wr(`SCSU_DATA_OFS, 8'h61);
        reg_wr(`SCSU_DATA_OFS, 8'h62);
        wait_done();
        reg_wr(`SCSU_STAT_OFS, 8'hbf);
        rd_chk(`SCSU_STAT_OFS, 8'h98, "collision write 0");
        rd_chk(`SCSU_DATA_OFS, 8'h58, "last byte");
        rd_chk(`SCSU_STAT_OFS, 8'h80, "read clears");
        reg_wr(`SCSU_STAT_OFS, 8'h00);
        // Select driven low in mid-frame
        u_peer.load(8'h00, 1'b0, 1'b0);
        reg_wr(`SCSU_CTRL_OFS, 8'hc3);
        reg_wr(`SCSU_DATA_OFS, 8'h42);
        repeat (4) @(negedge clock_i);
        u_peer.drive_select(1'b0);
        repeat (8) @(negedge clock_i);
        `CHK("sck enable fault", 1'b0, sck_oe_o)
        `CHK("mosi enable fault", 1'b0, mosi_oe_o)
        rd_chk(`SCSU_CTRL_OFS, 8'h03, "control fault");
        reg_rd(`SCSU_STAT_OFS, v);
        `CHK("mode fault", 1'b1, v[`SCSU_MODF_BIT])
        `CHK("busy fault", 1'b0, v[`SCSU_BSY_BIT])
        reg_wr(`SCSU_STAT_OFS, 8'h00);
        rd_chk(`SCSU_STAT_OFS, 8'h00, "fault cleared");
        reg_wr(`SCSU_CTRL_OFS, 8'hc8);
        repeat (6) @(posedge clock_i);
        rd_chk(`SCSU_CTRL_OFS, 8'hc8, "select disabled");
        rd_chk(`SCSU_STAT_OFS, 8'h00, "no fault");
        u_peer.drive_select(1'b1);
        finish_test();
    end
endmodule
